/* logic/gim_pkg.sv */
// package of constants and types for the global interrupt mask logic
package gim_pkg;
   // ************************************************
   // register map
   // ************************************************
   localparam logic [7:0] MASK_ZERO_ADDR  = 8'h04;
   localparam logic [7:0] MASK_ONE_ADDR   = 8'h05;
   localparam logic [7:0] MASK_ZERO_RESET = 8'h7F;
   localparam logic [7:0] MASK_ONE_RESET  = 8'h23;
   localparam logic [7:0] MASK_ZERO_WMASK = 8'h7F;
   localparam logic [7:0] MASK_ONE_WMASK  = 8'h3F;
   localparam logic [7:0] READ_IDLE       = 8'h00;
   localparam int         NUM_FLAGS       = 13;

   // ************************************************
   // flag vector layout: mask0 bits 6..0, then mask1 bits 5..0
   // ************************************************
   localparam int ONE_BASE = 7;

   // ************************************************
   // field positions, shared by mask bits and flag bits
   // ************************************************
   localparam int DROPOUT_BIT     = 6;
   localparam int THERM_TWO_BIT   = 5;
   localparam int THERM_ONE_BIT   = 4;
   localparam int ENABLE_RISE_BIT = 3;
   localparam int ENABLE_FALL_BIT = 2;
   localparam int GPIO_RISE_BIT   = 1;
   localparam int GPIO_FALL_BIT   = 0;
   localparam int ZERO_BITS       = 7;
   localparam int ONE_BITS        = 6;

   typedef struct packed {
      logic       wr_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gim_wr_t;
endpackage : gim_pkg

/* logic/gim_top.sv */
// global interrupt mask registers and interrupt request driver
`timescale 1ns/1ps
`default_nettype none
module gim_top (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          resetn,
   // register write port and readback
   input  wire gim_pkg::gim_wr_t              reg_wr,
   input  wire logic [7:0]                    rd_addr,
   output logic [7:0]                         rd_data,
   // latched event flags, same clock
   input  wire logic [gim_pkg::NUM_FLAGS-1:0] flags,
   // open-drain interrupt request
   output logic                               interrupt_request_n,
   output logic                               interrupt_request_oe
);
   logic [7:0]                    mask_zero_ff;
   logic [7:0]                    nxt_mask_zero;
   logic [7:0]                    mask_one_ff;
   logic [7:0]                    nxt_mask_one;
   logic [7:0]                    rd_data_ff;
   logic [7:0]                    nxt_rd_data;
   logic [gim_pkg::NUM_FLAGS-1:0] flags_prev_ff;
   logic [gim_pkg::NUM_FLAGS-1:0] nxt_flags_prev;
   logic                          irq_ff;
   logic                          nxt_irq;
   logic [gim_pkg::NUM_FLAGS-1:0] mask_vec;
   // one assign per bit, so this one is a net
   wire  logic [gim_pkg::NUM_FLAGS-1:0] rise_vec;

   // ************************************************
   // decode helpers
   // ************************************************
   // write strobe aimed at one mask register
   function automatic logic f_wr_hit(
      input gim_pkg::gim_wr_t wr,
      input logic [7:0]       addr
   );
      return wr.wr_en && (wr.addr == addr);
   endfunction : f_wr_hit

   // ************************************************
   // mask registers
   // ************************************************
   always_comb begin
      nxt_mask_zero = mask_zero_ff;
      nxt_mask_one  = mask_one_ff;
      // reserved bits cut on write, so they always read back as zero
      if (f_wr_hit(reg_wr, gim_pkg::MASK_ZERO_ADDR)) begin
         nxt_mask_zero = reg_wr.wdata & gim_pkg::MASK_ZERO_WMASK;
      end
      if (f_wr_hit(reg_wr, gim_pkg::MASK_ONE_ADDR)) begin
         nxt_mask_one = reg_wr.wdata & gim_pkg::MASK_ONE_WMASK;
      end
      // readback registered, one cycle after the address
      unique case (rd_addr)
         gim_pkg::MASK_ZERO_ADDR: nxt_rd_data = mask_zero_ff;
         gim_pkg::MASK_ONE_ADDR:  nxt_rd_data = mask_one_ff;
         default:                 nxt_rd_data = gim_pkg::READ_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mask_zero_ff <= gim_pkg::MASK_ZERO_RESET;
         mask_one_ff  <= gim_pkg::MASK_ONE_RESET;
         rd_data_ff   <= gim_pkg::READ_IDLE;
      end else begin
         mask_zero_ff <= nxt_mask_zero;
         mask_one_ff  <= nxt_mask_one;
         rd_data_ff   <= nxt_rd_data;
      end
   end

   assign rd_data = rd_data_ff;

   // ************************************************
   // edge detect and request
   // ************************************************
   // flag order matches the two masks laid end to end
   assign mask_vec = {mask_one_ff[gim_pkg::ONE_BITS-1:0],
                      mask_zero_ff[gim_pkg::ZERO_BITS-1:0]};

   // edge only: a flag already high when its mask clears stays silent
   for (genvar gi = 0; gi < gim_pkg::NUM_FLAGS; gi++) begin : g_edge
      assign rise_vec[gi] = flags[gi] & ~flags_prev_ff[gi] & ~mask_vec[gi];
   end

   always_comb begin
      nxt_flags_prev = flags;
      nxt_irq        = irq_ff;
      if (|rise_vec) begin
         nxt_irq = 1'b1;
      end else if (flags == '0) begin
         // a new edge wins over release in the same cycle
         nxt_irq = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flags_prev_ff <= '0;
         irq_ff        <= 1'b0;
      end else begin
         flags_prev_ff <= nxt_flags_prev;
         irq_ff        <= nxt_irq;
      end
   end

   // pin driven low only while asserting; released pin is pulled up
   assign interrupt_request_n  = 1'b0;
   assign interrupt_request_oe = irq_ff;

   // ************************************************
   // checks
   // ************************************************
   // one source rising while its mask bit is clear
   sequence s_unmasked_rise;
      flags[gim_pkg::DROPOUT_BIT] && !flags_prev_ff[gim_pkg::DROPOUT_BIT]
         && !mask_zero_ff[gim_pkg::DROPOUT_BIT];
   endsequence

   sequence s_thermal_two_rise;
      flags[gim_pkg::THERM_TWO_BIT] && !flags_prev_ff[gim_pkg::THERM_TWO_BIT]
         && !mask_zero_ff[gim_pkg::THERM_TWO_BIT];
   endsequence

   sequence s_thermal_one_rise;
      flags[gim_pkg::THERM_ONE_BIT] && !flags_prev_ff[gim_pkg::THERM_ONE_BIT]
         && !mask_zero_ff[gim_pkg::THERM_ONE_BIT];
   endsequence

   sequence s_enable_rise;
      flags[gim_pkg::ENABLE_RISE_BIT] && !flags_prev_ff[gim_pkg::ENABLE_RISE_BIT]
         && !mask_zero_ff[gim_pkg::ENABLE_RISE_BIT];
   endsequence

   sequence s_enable_fall;
      flags[gim_pkg::ENABLE_FALL_BIT] && !flags_prev_ff[gim_pkg::ENABLE_FALL_BIT]
         && !mask_zero_ff[gim_pkg::ENABLE_FALL_BIT];
   endsequence

   sequence s_gpio_rise;
      flags[gim_pkg::GPIO_RISE_BIT] && !flags_prev_ff[gim_pkg::GPIO_RISE_BIT]
         && !mask_zero_ff[gim_pkg::GPIO_RISE_BIT];
   endsequence

   sequence s_gpio_fall;
      flags[gim_pkg::GPIO_FALL_BIT] && !flags_prev_ff[gim_pkg::GPIO_FALL_BIT]
         && !mask_zero_ff[gim_pkg::GPIO_FALL_BIT];
   endsequence

   // request up while some flag is still pending
   sequence s_pending;
      interrupt_request_oe && (flags != '0);
   endsequence

   // nothing pending now or a cycle ago
   sequence s_all_clear;
      (flags == '0) && ($past(flags) == '0);
   endsequence

   a_dropout_assert: assert property (@(posedge clock) disable iff (!resetn)
      s_unmasked_rise |=> interrupt_request_oe)
      else $error("unmasked dropout rise did not assert request");

   a_thermal_two: assert property (@(posedge clock) disable iff (!resetn)
      s_thermal_two_rise |=> interrupt_request_oe)
      else $error("unmasked thermal two rise did not assert request");

   a_thermal_one: assert property (@(posedge clock) disable iff (!resetn)
      s_thermal_one_rise |=> interrupt_request_oe)
      else $error("unmasked thermal one rise did not assert request");

   a_masked_quiet: assert property (@(posedge clock) disable iff (!resetn)
      (!interrupt_request_oe && (rise_vec == '0)) |=> !interrupt_request_oe)
      else $error("request asserted without unmasked rise");

   a_release_clear: assert property (@(posedge clock) disable iff (!resetn)
      s_pending |=> interrupt_request_oe)
      else $error("request released while flags pending");

   a_release_done: assert property (@(posedge clock) disable iff (!resetn)
      s_all_clear |=> !interrupt_request_oe)
      else $error("request held after all flags cleared");

   a_enable_edge: assert property (@(posedge clock) disable iff (!resetn)
      s_enable_rise |=> interrupt_request_oe)
      else $error("unmasked enable rise flag did not assert request");

   a_enable_fall: assert property (@(posedge clock) disable iff (!resetn)
      s_enable_fall |=> interrupt_request_oe)
      else $error("unmasked enable fall flag did not assert request");

   a_gpio_rise: assert property (@(posedge clock) disable iff (!resetn)
      s_gpio_rise |=> interrupt_request_oe)
      else $error("unmasked gpio0 rise flag did not assert request");

   a_gpio_edge: assert property (@(posedge clock) disable iff (!resetn)
      s_gpio_fall |=> interrupt_request_oe)
      else $error("unmasked gpio0 fall flag did not assert request");

   // writes land on the next edge with reserved bits cut
   a_write_zero: assert property (@(posedge clock) disable iff (!resetn)
      f_wr_hit(reg_wr, gim_pkg::MASK_ZERO_ADDR)
      |=> mask_zero_ff == ($past(reg_wr.wdata) & gim_pkg::MASK_ZERO_WMASK))
      else $error("mask zero write did not land");

   a_write_one: assert property (@(posedge clock) disable iff (!resetn)
      f_wr_hit(reg_wr, gim_pkg::MASK_ONE_ADDR)
      |=> mask_one_ff == ($past(reg_wr.wdata) & gim_pkg::MASK_ONE_WMASK))
      else $error("mask one write did not land");

   // masks move only on a write strobe
   a_mask_hold: assert property (@(posedge clock) disable iff (!resetn)
      !reg_wr.wr_en |=> $stable(mask_zero_ff) && $stable(mask_one_ff))
      else $error("mask changed without a write");

   // every source on its own, with its mask clear and with it set
   for (genvar gs = 0; gs < gim_pkg::NUM_FLAGS; gs++) begin : g_src_chk
      a_source_rise: assert property (@(posedge clock) disable iff (!resetn)
         (flags[gs] && !flags_prev_ff[gs] && !mask_vec[gs]) |=> interrupt_request_oe)
         else $error("unmasked source rise did not assert request");

      a_source_masked: assert property (@(posedge clock) disable iff (!resetn)
         (flags[gs] && !flags_prev_ff[gs] && mask_vec[gs] && !interrupt_request_oe
          && (rise_vec == '0)) |=> !interrupt_request_oe)
         else $error("masked source rise asserted request");
   end
endmodule : gim_top
`default_nettype wire

/* verification/gim_host_model.sv */
// host side model of the open-drain interrupt line
`timescale 1ns/1ps
`default_nettype none
module gim_host_model (
   // pin from the device
   input  wire logic pin_n,
   input  wire logic pin_oe,
   // level the host sees
   output logic      line_n
);
   // pull-up holds the line high whenever the device lets go
   assign line_n = pin_oe ? pin_n : 1'b1;
endmodule : gim_host_model
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the interrupt mask logic
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                          clock = 1'b0;
   logic                          resetn = 1'b0;
   gim_pkg::gim_wr_t              reg_wr = '0;
   logic [7:0]                    rd_addr = 8'h00;
   logic [7:0]                    rd_data;
   logic [gim_pkg::NUM_FLAGS-1:0] flags = '0;
   logic                          irq_n;
   logic                          irq_oe;
   logic                          line_n;
   int                            n_mismatch = 0;
   int                            check_count = 0;
   int                            cyc = 0;
   always #50 clock = ~clock;
   gim_top dut (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .rd_addr(rd_addr),
      .rd_data(rd_data), .flags(flags), .interrupt_request_n(irq_n),
      .interrupt_request_oe(irq_oe));
   gim_host_model host (.pin_n(irq_n), .pin_oe(irq_oe), .line_n(line_n));
   task automatic step;
      @(posedge clock);
      #1;
   endtask : step
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // a step first, so the strobe never falls and rises in one time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step;
      reg_wr = '{1'b1, a, d};
      step;
      reg_wr.wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_addr = a;
      step;
      cmp(rd_data, e);
   endtask : rd
   task automatic t_regs;
      rd(8'h04, 8'h7F);
      rd(8'h05, 8'h23);
      rd(8'h06, 8'h00);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'h3F);
      wr(8'h04, 8'hFF);
      wr(8'h07, 8'h00);
      rd(8'h04, 8'h7F);
      $display("test regs done");
   endtask : t_regs
   task automatic t_sources;
      for (int i = 0; i < 7; i++) begin
         wr(8'h04, 8'h00);
         flags[i] = 1'b1;
         step;
         cmp({7'h00, line_n}, 8'h00);
         flags[6:5] = 2'b11;
         step;
         flags = '0;
         cmp({7'h00, line_n}, 8'h00);
         step;
         cmp({7'h00, line_n}, 8'h01);
         wr(8'h04, 8'h01 << i);
         flags[i] = 1'b1;
         step;
         step;
         cmp({7'h00, line_n}, 8'h01);
         flags = '0;
      end
      $display("test sources done");
   endtask : t_sources
   task automatic t_group_one;
      // a flag already high when its mask clears stays silent
      wr(8'h04, 8'h7F);
      flags[4] = 1'b1;
      step;
      wr(8'h04, 8'h00);
      step;
      cmp({7'h00, line_n}, 8'h01);
      flags = '0;
      for (int j = 7; j < gim_pkg::NUM_FLAGS; j++) begin
         wr(8'h05, 8'h3F);
         flags[j] = 1'b1;
         step;
         step;
         cmp({7'h00, line_n}, 8'h01);
         flags = '0;
         wr(8'h05, 8'h00);
         flags[j] = 1'b1;
         step;
         cmp({7'h00, line_n}, 8'h00);
         flags = '0;
         step;
         cmp({7'h00, line_n}, 8'h01);
      end
      $display("test group one done");
   endtask : t_group_one
   task automatic t_reset;
      wr(8'h04, 8'h00);
      flags[2] = 1'b1;
      step;
      cmp({7'h00, line_n}, 8'h00);
      flags = '0;
      resetn = 1'b0;
      #1;
      cmp({7'h00, line_n}, 8'h01);
      step;
      step;
      resetn = 1'b1;
      rd(8'h04, 8'h7F);
      rd(8'h05, 8'h23);
      $display("test reset done");
   endtask : t_reset
   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   // the whole run needs about 140 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         end_of_test;
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      #1;
      resetn = 1'b1;
      t_regs;
      t_sources;
      t_group_one;
      t_reset;
      end_of_test;
   end
endmodule : tb
`default_nettype wire
